// ### hw/dibs_pkg.sv
// Package with constants and carrier types for the dual image boot selector.
package dibs_pkg;

  localparam logic [31:0] DIBS_WIDTH_DETECT_WORD = 32'h0000_0000;
  localparam logic [31:0] DIBS_SYNC_WORD         = 32'hAA99_5566;
  localparam logic [31:0] DIBS_PAD_WORD          = 32'hFFFF_FFFF;
  localparam logic [31:0] DIBS_PAR_UPDATE_ADDR   = 32'h0010_0000;
  localparam logic [31:0] DIBS_SER_UPDATE_ADDR   = 32'h0020_0000;
  localparam logic [31:0] DIBS_PAR_SWITCH_ADDR   = 32'h0000_FFFE;
  localparam logic [31:0] DIBS_SER_SWITCH_ADDR   = 32'h0000_0FFC;
  localparam logic [31:0] DIBS_CRC_INIT          = 32'hFFFF_FFFF;
  localparam logic [31:0] DIBS_CRC_POLY          = 32'hEDB8_8320;
  localparam logic [31:0] DIBS_JUMP_RESET        = 32'h0000_0000;

  typedef enum logic [1:0] {
    DIBS_IMG_NONE,
    DIBS_IMG_GOLDEN,
    DIBS_IMG_UPDATE
  } dibs_img_t;

  typedef enum {
    DIBS_ST_SWITCH,
    DIBS_ST_HEADER,
    DIBS_ST_SEARCH,
    DIBS_ST_DONE
  } dibs_state_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } dibs_word_t;

  typedef struct packed {
    logic        selValid;
    dibs_img_t   image;
    logic [31:0] startAddr;
    logic        reprogram;
  } dibs_sel_t;

endpackage : dibs_pkg

// ### hw/dual_image_boot_selector.sv
// Boot image selector that watches the flash word stream and picks the image.
`timescale 1ns/1ps

module dual_image_boot_selector
  import dibs_pkg::*;
#(
  parameter logic [31:0] UPDATE_PAR_ADDR = DIBS_PAR_UPDATE_ADDR,
  parameter logic [31:0] UPDATE_SER_ADDR = DIBS_SER_UPDATE_ADDR,
  parameter logic [31:0] SWITCH_PAR_ADDR = DIBS_PAR_SWITCH_ADDR,
  parameter logic [31:0] SWITCH_SER_ADDR = DIBS_SER_SWITCH_ADDR
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        serialMode,
  input  wire logic        start,
  input  wire dibs_word_t  flashWord,
  input  wire logic        crcClear,
  input  wire logic        crcByteValid,
  input  wire logic [7:0]  crcByte,
  input  wire logic        crcCheck,
  input  wire logic [31:0] crcStored,
  output dibs_sel_t        sel,
  output logic             crcDone,
  output logic             crcMismatch
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.
  // The reset takes hold at once but is let go only on a clock edge, so every flop of
  // the selector leaves reset in the same cycle as its neighbours.
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State record.
  // Selection and checksum share one record, registered by a single process. The jump
  // address is held apart from the output until the command word arrives, so a header cut
  // short after the address never shows a half-made decision.
  typedef struct packed {
    dibs_state_t state;
    logic        serial;
    logic        gotAddr;
    logic [31:0] jumpAddr;
    dibs_sel_t   sel;
    logic [31:0] crc;
    logic        crcDone;
    logic        crcBad;
  } dibs_regs_t;

  dibs_regs_t st_r;
  dibs_regs_t st_nxt;

  // One byte of the reflected CRC32, least significant bit first. The final inversion of
  // the standard checksum is left out on purpose: the stored value is already the
  // complement, so the raw register can be compared with it directly.
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] v;
    v = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ DIBS_CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction : crcStep

  // The flash word of interest: detect word in parallel mode, sync in serial.
  function automatic logic isKey(input logic ser, input logic [31:0] d);
    logic hit;
    if (ser) begin
      hit = (d == DIBS_SYNC_WORD);
    end else begin
      hit = (d == DIBS_WIDTH_DETECT_WORD);
    end
    return hit;
  endfunction : isKey

  // Picks the parallel or serial form of a flash address.
  function automatic logic [31:0] modeAddr(input logic        ser,
                                           input logic [31:0] parAddr,
                                           input logic [31:0] serAddr);
    logic [31:0] a;
    if (ser) begin
      a = serAddr;
    end else begin
      a = parAddr;
    end
    return a;
  endfunction : modeAddr

  // Builds a finished decision; the reprogram strobe goes only with a jump to the update.
  function automatic dibs_sel_t makeSel(input dibs_img_t   img,
                                        input logic [31:0] addr,
                                        input logic        jump);
    dibs_sel_t s;
    s           = '0;
    s.selValid  = 1'b1;
    s.image     = img;
    s.startAddr = addr;
    s.reprogram = jump;
    return s;
  endfunction : makeSel

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  // A boot walks SWITCH, then HEADER or SEARCH, then DONE. Words below the switch location
  // are passed over, so padding in the first segment can never start a boot. Once DONE is
  // reached every further word is ignored until the next start, because the loader has by
  // then handed the flash over to the chosen image.
  always_comb begin
    logic [31:0] swAddr;
    logic [31:0] updAddr;
    swAddr  = modeAddr(st_r.serial, SWITCH_PAR_ADDR, SWITCH_SER_ADDR);
    updAddr = modeAddr(st_r.serial, UPDATE_PAR_ADDR, UPDATE_SER_ADDR);
    st_nxt  = st_r;
    st_nxt.sel.reprogram = 1'b0;
    if (start) begin
      st_nxt.state = DIBS_ST_SWITCH;
      st_nxt.serial = serialMode;
      st_nxt.gotAddr = 1'b0;
      st_nxt.sel = '0;
    end else if (flashWord.valid) begin
      case (st_r.state)
        DIBS_ST_SWITCH: begin
          if (flashWord.addr == swAddr) begin
            if (isKey(st_r.serial, flashWord.data)) begin
              st_nxt.state = DIBS_ST_HEADER;
            end else begin
              st_nxt.state = DIBS_ST_SEARCH;
            end
          end
        end
        DIBS_ST_HEADER: begin
          // Header two is decoded only after the switch word matched.
          // Only a word equal to the configured update address is taken as the target; a
          // header naming any other address is passed over, and the selector waits here for start or a later word equal to the update address.
          if (flashWord.data == updAddr) begin
            st_nxt.jumpAddr = flashWord.data;
            st_nxt.gotAddr = 1'b1;
          end else if (st_r.gotAddr && flashWord.data != DIBS_PAD_WORD
                       && flashWord.data != DIBS_SYNC_WORD) begin
            st_nxt.state = DIBS_ST_DONE;
            st_nxt.sel   = makeSel(DIBS_IMG_UPDATE, st_r.jumpAddr, 1'b1);
          end
        end
        DIBS_ST_SEARCH: begin
          // Header two words are skipped; the golden image key is taken.
          // The golden start is the address of its key word, where loading resumes.
          if (flashWord.addr > swAddr && isKey(st_r.serial, flashWord.data)) begin
            st_nxt.state = DIBS_ST_DONE;
            st_nxt.sel   = makeSel(DIBS_IMG_GOLDEN, flashWord.addr, 1'b0);
          end
        end
        default: begin
          st_nxt.state = DIBS_ST_DONE;
        end
      endcase
    end
    // Update area checksum, kept apart from the selection path.
    // Clear wins over a byte and a byte over a check: a clear restarts the sum, so a check
    // in that cycle would have no finished sum to judge. Bytes must arrive in area order.
    if (crcClear) begin
      st_nxt.crc = DIBS_CRC_INIT;
      st_nxt.crcDone = 1'b0;
      st_nxt.crcBad = 1'b0;
    end else if (crcByteValid) begin
      st_nxt.crc = crcStep(st_r.crc, crcByte);
    end else if (crcCheck) begin
      // The stored value is already the complement, so compare the raw register.
      st_nxt.crcDone = 1'b1;
      st_nxt.crcBad = (st_r.crc != crcStored);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      st_r <= '{
        state:    DIBS_ST_SWITCH,
        serial:   1'b0,
        gotAddr:  1'b0,
        jumpAddr: DIBS_JUMP_RESET,
        sel:      '0,
        crc:      DIBS_CRC_INIT,
        crcDone:  1'b0,
        crcBad:   1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  assign sel = st_r.sel;
  assign crcDone = st_r.crcDone;
  assign crcMismatch = st_r.crcBad;

endmodule : dual_image_boot_selector

// ### verif/dibs_sel_monitor.sv
// Assertion checker on the boot selector ports.
`timescale 1ns/1ps
module dibs_sel_monitor
  import dibs_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire logic      start,
  input wire logic      crcClear,
  input wire logic      crcByteValid,
  input wire logic      crcCheck,
  input wire dibs_sel_t sel,
  input wire logic      crcDone,
  input wire logic      crcMismatch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence sRepPulse;
    sel.reprogram ##1 !sel.reprogram;
  endsequence
  rep_pulse_a: assert property ($rose(sel.reprogram) |-> sRepPulse)
    else $error("reprogram pulse too long");
  rep_update_a: assert property (sel.reprogram |-> sel.image == DIBS_IMG_UPDATE)
    else $error("reprogram without update");
  golden_norep_a: assert property (sel.image == DIBS_IMG_GOLDEN |-> !sel.reprogram)
    else $error("golden with reprogram");
  img_valid_a: assert property (sel.selValid |-> sel.image != DIBS_IMG_NONE)
    else $error("valid without image");
  start_clr_a: assert property (start |=> !sel.selValid)
    else $error("start left a decision");
  sel_hold_a: assert property (sel.selValid && !start |=> $stable(sel.startAddr))
    else $error("decision changed");
  crc_done_a: assert property (crcCheck && !crcClear && !crcByteValid && !start |=> crcDone)
    else $error("check not done");
  crc_clr_a: assert property (crcClear && !start |=> !crcDone && !crcMismatch)
    else $error("clear left flags");
endmodule : dibs_sel_monitor
bind dual_image_boot_selector dibs_sel_monitor mon (.ref_clk, .rst_n, .start, .crcClear,
  .crcByteValid, .crcCheck, .sel, .crcDone, .crcMismatch);

// ### verif/dibs_flash_model.sv
// Flash model streaming words around the switch location.
`timescale 1ns/1ps
module dibs_flash_model
  import dibs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic go,
  input  wire logic serMode,
  input  wire logic good,
  output dibs_word_t flashWord
);
  logic [31:0] key;
  assign key = serMode ? DIBS_SYNC_WORD : DIBS_WIDTH_DETECT_WORD;
  initial flashWord = '0;
  // A key word sits before the switch location so a loader that does not skip it picks wrongly.
  // Parallel addresses count 16-bit units, so each 32-bit word moves the address on by two.
  always @(posedge go) begin
    for (int i = 0; i < 7; i++) begin
      @(negedge ref_clk);
      flashWord.valid <= 1'b1;
      flashWord.addr <= (serMode ? DIBS_SER_SWITCH_ADDR : DIBS_PAR_SWITCH_ADDR)
        + 32'(i - 1) * (serMode ? 32'd4 : 32'd2);
      case (i)
        0, 5: flashWord.data <= key;
        1: flashWord.data <= good ? key : DIBS_PAD_WORD;
        2: flashWord.data <= serMode ? DIBS_SER_UPDATE_ADDR : DIBS_PAR_UPDATE_ADDR;
        3: flashWord.data <= 32'h0000_000F;
        4: flashWord.data <= serMode ? DIBS_WIDTH_DETECT_WORD : DIBS_SYNC_WORD;
        default: flashWord.data <= DIBS_PAD_WORD;
      endcase
    end
    @(negedge ref_clk);
    flashWord.valid <= 1'b0;
    flashWord.data <= ~flashWord.data;
  end
endmodule : dibs_flash_model

// ### verif/dual_image_boot_selector_test.sv
// Self-checking bench for the boot selector.
`timescale 1ns/1ps
module dual_image_boot_selector_test
  import dibs_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, serialMode = 0, start = 0, go = 0, good = 0;
  logic crcClear = 0, crcByteValid = 0, crcCheck = 0, crcDone, crcMismatch;
  logic [7:0] crcByte = '0;
  logic [31:0] crcStored = '0;
  dibs_word_t flashWord;
  dibs_sel_t sel;
  int mismatches = 0, compares = 0, cyc = 0, reps = 0;
  dual_image_boot_selector uut (.ref_clk, .rst_n, .serialMode, .start, .flashWord, .crcClear,
    .crcByteValid, .crcByte, .crcCheck, .crcStored, .sel, .crcDone, .crcMismatch);
  dibs_flash_model flash (.ref_clk, .go, .serMode(serialMode), .good, .flashWord);
  initial forever #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    cyc++;
    if (sel.reprogram === 1'b1) reps++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  task chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task boot(logic m, logic g, logic [31:0] img, logic [31:0] adr, int np);
    @(negedge ref_clk);
    serialMode = m; good = g; start = 1; reps = 0;
    @(negedge ref_clk);
    start = 0; go = 1;
    @(negedge ref_clk);
    go = 0;
    for (int i = 0; i < 20 && sel.selValid !== 1'b1; i++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
    chk("valid", sel.selValid, 1);
    chk("image", sel.image, img);
    chk("addr", sel.startAddr, adr);
    chk("pulses", reps, np);
  endtask : boot
  function automatic logic [31:0] crcOf();
    logic [31:0] c;
    c = DIBS_CRC_INIT;
    for (int i = 1; i <= 4; i++) begin
      c ^= 32'(i);
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ DIBS_CRC_POLY : c >> 1;
    end
    // The standard checksum ends with an inversion.
    return ~c;
  endfunction : crcOf
  task crc_run(logic bad);
    @(negedge ref_clk);
    crcClear = 1;
    for (int i = 1; i <= 4; i++) begin
      @(negedge ref_clk);
      crcClear = 0; crcByteValid = 1; crcByte = 8'(i);
    end
    @(negedge ref_clk);
    crcByteValid = 0; crcCheck = 1; crcStored = ~crcOf() ^ 32'(bad);
    @(negedge ref_clk);
    crcCheck = 0;
    @(negedge ref_clk);
    chk("done", crcDone, 1);
    chk("mismatch", crcMismatch, 32'(bad));
  endtask : crc_run
  localparam logic [31:0] PAR_BLOCK  = 32'h0001_0000; // Parallel erase block in 16-bit units.
  localparam logic [31:0] SER_SECTOR = 32'h0001_0000; // Serial erase sector in bytes.
  localparam logic [31:0] HDR2_UNITS = 32'h0000_0018; // Header part two in 16-bit units.
  localparam logic [31:0] GOLD_UNITS = 32'h000C_0000; // Modelled golden stream length.
  task layout_run;
    logic [31:0] img;
    img = (PAR_BLOCK + HDR2_UNITS + GOLD_UNITS + PAR_BLOCK - 1) / PAR_BLOCK * PAR_BLOCK;
    chk("par align", DIBS_PAR_UPDATE_ADDR % PAR_BLOCK, 0);
    chk("ser align", DIBS_SER_UPDATE_ADDR % SER_SECTOR, 0);
    chk("par room", 32'(img <= DIBS_PAR_UPDATE_ADDR), 1);
  endtask : layout_run
  task results;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    chk("reset valid", sel.selValid, 0);
    layout_run();
    boot(0, 1, DIBS_IMG_UPDATE, DIBS_PAR_UPDATE_ADDR, 1);
    boot(0, 0, DIBS_IMG_GOLDEN, DIBS_PAR_SWITCH_ADDR + 32'd8, 0);
    boot(1, 1, DIBS_IMG_UPDATE, DIBS_SER_UPDATE_ADDR, 1);
    boot(1, 0, DIBS_IMG_GOLDEN, DIBS_SER_SWITCH_ADDR + 32'd16, 0);
    crc_run(0);
    crc_run(1);
    results();
  end
endmodule : dual_image_boot_selector_test
